/* design/mcs_pkg.sv */
// Constants and types for the core special-function register block.
// Assumes one core clock and a CPU that drives SFR accesses on that clock.
package mcs_pkg;

  // Register addresses
  localparam logic [7:0] MCS_ADDR_SP   = 8'h81;
  localparam logic [7:0] MCS_ADDR_DPL  = 8'h82;
  localparam logic [7:0] MCS_ADDR_DPH  = 8'h83;
  localparam logic [7:0] MCS_ADDR_POWER_BAUD_CONTROL = 8'h87;
  localparam logic [7:0] MCS_ADDR_CFG  = 8'haf;
  localparam logic [7:0] MCS_ADDR_PSW  = 8'hd0;
  localparam logic [7:0] MCS_ADDR_ACC  = 8'he0;
  localparam logic [7:0] MCS_ADDR_B    = 8'hf0;

  // Address space split and bit addressing
  localparam int         MCS_SFR_SPACE_BIT = 7;
  localparam logic [7:0] MCS_BIT_BYTE_MASK = 8'hf8;

  // Reset values
  localparam logic [7:0] MCS_RST_SP   = 8'h07;
  localparam logic [7:0] MCS_RST_DPL  = 8'h00;
  localparam logic [7:0] MCS_RST_DPH  = 8'h00;
  localparam logic [7:0] MCS_RST_POWER_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] MCS_RST_CFG  = 8'h80;
  localparam logic [7:0] MCS_RST_PSW  = 8'h00;
  localparam logic [7:0] MCS_RST_ACC  = 8'h00;
  localparam logic [7:0] MCS_RST_B    = 8'h00;

  // Status word fields
  localparam int MCS_PSW_CY  = 7;
  localparam int MCS_PSW_AC  = 6;
  localparam int MCS_PSW_F0  = 5;
  localparam int MCS_PSW_RS1 = 4;
  localparam int MCS_PSW_RS0 = 3;
  localparam int MCS_PSW_OV  = 2;
  localparam int MCS_PSW_F1  = 1;
  localparam int MCS_PSW_P   = 0;
  localparam logic [7:0] MCS_PSW_STORE_MASK = 8'hfe;

  // Power/baud control fields
  localparam int         MCS_POWER_BAUD_CONTROL_BAUD  = 7;
  localparam logic [7:0] MCS_POWER_BAUD_CONTROL_WMASK = 8'h80;

  // Configuration fields
  localparam int         MCS_CFG_KEEP  = 7;
  localparam int         MCS_CFG_UART  = 6;
  localparam int         MCS_CFG_SPI   = 5;
  localparam int         MCS_CFG_MOD   = 4;
  localparam int         MCS_CFG_XR1   = 1;
  localparam int         MCS_CFG_XR0   = 0;
  localparam logic [7:0] MCS_CFG_WMASK = 8'hf3;

  // Bank base step: eight registers per bank
  localparam int MCS_BANK_SHIFT = 3;

  typedef enum logic [2:0] {
    MCS_OP_NONE, MCS_OP_ADD, MCS_OP_ADDC, MCS_OP_SUBB, MCS_OP_MUL, MCS_OP_DIV, MCS_OP_OTHER
  } mcs_alu_op_t;

  typedef enum logic [1:0] {MCS_SP_KEEP, MCS_SP_INC, MCS_SP_DEC} mcs_sp_op_t;

  typedef enum logic [3:0] {
    MCS_RID_NONE, MCS_RID_SP, MCS_RID_DPL, MCS_RID_DPH, MCS_RID_POWER_BAUD_CONTROL,
    MCS_RID_CFG, MCS_RID_PSW, MCS_RID_ACC, MCS_RID_B
  } mcs_rid_t;

  typedef struct packed {
    mcs_alu_op_t alu_op;
    logic        cy;
    logic        ac;
    logic        ov;
    logic        acc_we;
    logic [7:0]  acc;
    logic        b_we;
    logic [7:0]  b;
    mcs_sp_op_t  sp_op;
    logic        dptr_we;
    logic        dptr_inc;
    logic [15:0] dptr;
  } mcs_core_upd_t;

  typedef struct packed {
    logic [7:0] sp;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] power_baud_control;
    logic [7:0] cfg;
    logic [7:0] program_status;
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] rdata;
    logic       rvalid;
  } mcs_state_t;

endpackage : mcs_pkg

/* design/mcs_core_sfr.sv */
// Core special-function registers: status word, accumulator, B, data pointer,
// stack pointer, power/baud control and configuration byte.
// Assumes the CPU presents direct SFR accesses and instruction results on CLK.
`timescale 1ns/100ps

// Operation
// - Registers answer only direct accesses in upper 128 data addresses.
// - Accumulator E0, B F0, status D0 bit addressable; others byte only.
// - Carry, status bit 7, updated by add, addc, subb, mul, div.
// - Auxiliary carry, status bit 6, updated only by add and addc.
// - Status bits 5 and 1 are user flags, never changed implicitly.
// - Status bits 4:3 select register bank 0 to 3.
// - Overflow, status bit 2, updated by add, addc, subb, mul, div.
// - Status bit 0 keeps accumulator plus itself at even parity.
// - Power control resets zero; bit 7 doubles baud; 6:0 reserved.
// - Data pointer low and high bytes, reset zero, form 16-bit pointer.
// - Stack pointer is eight bits and resets to 7.
// - Configuration bit 6 selects standard or enhanced serial port.
// - Configuration bit 5 gives shared pins to I2C (0) or SPI (1).
// - Configuration bit 4 enables 38kHz modulation on selected pins.
// - Either configuration bit 1 or 0 enables MOVX to extended RAM.
module mcs_core_sfr
  import mcs_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic [7:0]    SFR_ADDR,
  input  wire logic          SFR_INDIRECT,
  input  wire logic          SFR_RD,
  input  wire logic          SFR_WR,
  input  wire logic          SFR_BIT_RD,
  input  wire logic          SFR_BIT_WR,
  input  wire logic [7:0]    SFR_WDATA,
  output logic               SFR_HIT,
  output logic [7:0]         SFR_RDATA,
  output logic               SFR_RVALID,
  input  wire mcs_core_upd_t CORE_UPD,
  input  wire logic [7:0]    CARRIER_PIN_SELECT,
  output logic [7:0]         ACC_OUT,
  output logic [7:0]         B_OUT,
  output logic [7:0]         PSW_OUT,
  output logic [15:0]        DPTR_OUT,
  output logic [7:0]         SP_OUT,
  output logic [1:0]         BANK_SEL,
  output logic [4:0]         BANK_BASE,
  output logic               BAUD_DOUBLE,
  output logic               UART_ENHANCE,
  output logic               SERIAL_PORT_SPI,
  output logic [7:0]         CARRIER_PIN_EN,
  output logic               XRAM_MOVX_EN,
  output logic               CFG_KEEP_LOW
);

  mcs_state_t r_r;
  mcs_state_t r_nxt;

  logic       parity;
  logic       any_acc;
  logic       bit_acc;
  logic [7:0] byte_addr;
  mcs_rid_t   rid;
  logic       hit;
  logic [7:0] cur_val;
  logic [7:0] new_val;
  logic [2:0] bit_idx;

  // Address to register decode
  function automatic mcs_rid_t sfr_decode(input logic [7:0] addr);
    case (addr)
      MCS_ADDR_SP:   sfr_decode = MCS_RID_SP;
      MCS_ADDR_DPL:  sfr_decode = MCS_RID_DPL;
      MCS_ADDR_DPH:  sfr_decode = MCS_RID_DPH;
      MCS_ADDR_POWER_BAUD_CONTROL: sfr_decode = MCS_RID_POWER_BAUD_CONTROL;
      MCS_ADDR_CFG:  sfr_decode = MCS_RID_CFG;
      MCS_ADDR_PSW:  sfr_decode = MCS_RID_PSW;
      MCS_ADDR_ACC:  sfr_decode = MCS_RID_ACC;
      MCS_ADDR_B:    sfr_decode = MCS_RID_B;
      default:       sfr_decode = MCS_RID_NONE;
    endcase
  endfunction : sfr_decode

  // Only accumulator, B and status take bit accesses
  function automatic logic bit_capable(input mcs_rid_t id);
    bit_capable = (id == MCS_RID_ACC) || (id == MCS_RID_B) || (id == MCS_RID_PSW);
  endfunction : bit_capable

  // Read view of a register
  function automatic logic [7:0] reg_view(input mcs_state_t s, input mcs_rid_t id, input logic par);
    case (id)
      MCS_RID_SP:   reg_view = s.sp;
      MCS_RID_DPL:  reg_view = s.data_pointer_low;
      MCS_RID_DPH:  reg_view = s.data_pointer_high;
      MCS_RID_POWER_BAUD_CONTROL: reg_view = s.power_baud_control & MCS_POWER_BAUD_CONTROL_WMASK;
      MCS_RID_CFG:  reg_view = s.cfg & MCS_CFG_WMASK;
      MCS_RID_PSW:  reg_view = (s.program_status & MCS_PSW_STORE_MASK) | {7'h00, par};
      MCS_RID_ACC:  reg_view = s.acc;
      MCS_RID_B:    reg_view = s.b;
      default:      reg_view = 8'h00;
    endcase
  endfunction : reg_view

  // Even parity over accumulator and parity bit
  assign parity = ^r_r.acc;

  // Access decode
  always_comb begin
    any_acc   = SFR_RD | SFR_WR | SFR_BIT_RD | SFR_BIT_WR;
    bit_acc   = SFR_BIT_RD | SFR_BIT_WR;
    byte_addr = bit_acc ? (SFR_ADDR & MCS_BIT_BYTE_MASK) : SFR_ADDR;
    bit_idx   = SFR_ADDR[2:0];
    rid       = sfr_decode(byte_addr);
    hit       = any_acc && !SFR_INDIRECT && SFR_ADDR[MCS_SFR_SPACE_BIT]
                && (rid != MCS_RID_NONE) && (!bit_acc || bit_capable(rid));
    cur_val   = reg_view(r_r, rid, parity);
    new_val   = cur_val;
    if (SFR_BIT_WR) begin
      new_val[bit_idx] = SFR_WDATA[0];
    end else begin
      new_val = SFR_WDATA;
    end
  end

  assign SFR_HIT = hit;

  // Next state
  always_comb begin
    r_nxt        = r_r;
    r_nxt.rvalid = 1'b0;

    // Instruction flag updates
    case (CORE_UPD.alu_op)
      MCS_OP_ADD, MCS_OP_ADDC: begin
        r_nxt.program_status[MCS_PSW_CY] = CORE_UPD.cy;
        r_nxt.program_status[MCS_PSW_AC] = CORE_UPD.ac;
        r_nxt.program_status[MCS_PSW_OV] = CORE_UPD.ov;
      end
      MCS_OP_SUBB, MCS_OP_MUL, MCS_OP_DIV: begin
        r_nxt.program_status[MCS_PSW_CY] = CORE_UPD.cy;
        r_nxt.program_status[MCS_PSW_OV] = CORE_UPD.ov;
      end
      default: begin
        r_nxt.program_status = r_r.program_status;
      end
    endcase

    // Instruction results
    if (CORE_UPD.acc_we) begin
      r_nxt.acc = CORE_UPD.acc;
    end
    if (CORE_UPD.b_we) begin
      r_nxt.b = CORE_UPD.b;
    end
    case (CORE_UPD.sp_op)
      MCS_SP_INC: begin
        r_nxt.sp = r_r.sp + 8'h01;
      end
      MCS_SP_DEC: begin
        r_nxt.sp = r_r.sp - 8'h01;
      end
      default: begin
        r_nxt.sp = r_r.sp;
      end
    endcase
    if (CORE_UPD.dptr_we) begin
      {r_nxt.data_pointer_high, r_nxt.data_pointer_low} = CORE_UPD.dptr;
    end else if (CORE_UPD.dptr_inc) begin
      {r_nxt.data_pointer_high, r_nxt.data_pointer_low} = {r_r.data_pointer_high, r_r.data_pointer_low} + 16'h0001;
    end

    // Direct writes take priority over instruction results
    if (hit && (SFR_WR || SFR_BIT_WR)) begin
      case (rid)
        MCS_RID_SP: begin
          r_nxt.sp = new_val;
        end
        MCS_RID_DPL: begin
          r_nxt.data_pointer_low = new_val;
        end
        MCS_RID_DPH: begin
          r_nxt.data_pointer_high = new_val;
        end
        MCS_RID_POWER_BAUD_CONTROL: begin
          r_nxt.power_baud_control = new_val & MCS_POWER_BAUD_CONTROL_WMASK;
        end
        MCS_RID_CFG: begin
          r_nxt.cfg = new_val & MCS_CFG_WMASK;
        end
        MCS_RID_PSW: begin
          r_nxt.program_status = new_val & MCS_PSW_STORE_MASK;
        end
        MCS_RID_ACC: begin
          r_nxt.acc = new_val;
        end
        MCS_RID_B: begin
          r_nxt.b = new_val;
        end
        default: begin
          r_nxt.b = r_nxt.b;
        end
      endcase
    end

    // Read answer one cycle later
    if (SFR_RD || SFR_BIT_RD) begin
      r_nxt.rvalid = 1'b1;
      if (!hit) begin
        r_nxt.rdata = 8'h00;
      end else if (SFR_BIT_RD) begin
        r_nxt.rdata = {7'h00, cur_val[bit_idx]};
      end else begin
        r_nxt.rdata = cur_val;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_r.sp     <= MCS_RST_SP;
      r_r.data_pointer_low    <= MCS_RST_DPL;
      r_r.data_pointer_high    <= MCS_RST_DPH;
      r_r.power_baud_control   <= MCS_RST_POWER_BAUD_CONTROL;
      r_r.cfg    <= MCS_RST_CFG;
      r_r.program_status    <= MCS_RST_PSW;
      r_r.acc    <= MCS_RST_ACC;
      r_r.b      <= MCS_RST_B;
      r_r.rdata  <= 8'h00;
      r_r.rvalid <= 1'b0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Register views
  assign SFR_RDATA  = r_r.rdata;
  assign SFR_RVALID = r_r.rvalid;
  assign ACC_OUT    = r_r.acc;
  assign B_OUT      = r_r.b;
  assign PSW_OUT    = reg_view(r_r, MCS_RID_PSW, parity);
  assign DPTR_OUT   = {r_r.data_pointer_high, r_r.data_pointer_low};
  assign SP_OUT     = r_r.sp;

  // Bank select
  assign BANK_SEL  = {r_r.program_status[MCS_PSW_RS1], r_r.program_status[MCS_PSW_RS0]};
  assign BANK_BASE = 5'(BANK_SEL) << MCS_BANK_SHIFT;

  // Control fields
  assign BAUD_DOUBLE     = r_r.power_baud_control[MCS_POWER_BAUD_CONTROL_BAUD];
  assign UART_ENHANCE    = r_r.cfg[MCS_CFG_UART];
  assign SERIAL_PORT_SPI = r_r.cfg[MCS_CFG_SPI];
  assign CARRIER_PIN_EN  = CARRIER_PIN_SELECT & {8{r_r.cfg[MCS_CFG_MOD]}};
  assign XRAM_MOVX_EN    = r_r.cfg[MCS_CFG_XR1] | r_r.cfg[MCS_CFG_XR0];
  assign CFG_KEEP_LOW    = ~r_r.cfg[MCS_CFG_KEEP];

endmodule : mcs_core_sfr

/* verification/mcs_core_sfr_checker.sv */
// Port assertions for the core register block.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module mcs_core_sfr_checker
  import mcs_pkg::*;
(
  input wire logic          CLK,
  input wire logic          RST_N,
  input wire logic [7:0]    SFR_ADDR,
  input wire logic          SFR_INDIRECT,
  input wire logic          SFR_RD,
  input wire logic          SFR_WR,
  input wire logic          SFR_BIT_WR,
  input wire logic [7:0]    SFR_WDATA,
  input wire logic          SFR_HIT,
  input wire logic [7:0]    SFR_RDATA,
  input wire logic          SFR_RVALID,
  input wire mcs_core_upd_t CORE_UPD,
  input wire logic [7:0]    CARRIER_PIN_SELECT,
  input wire logic [7:0]    ACC_OUT,
  input wire logic [7:0]    PSW_OUT,
  input wire logic [1:0]    BANK_SEL,
  input wire logic [4:0]    BANK_BASE,
  input wire logic [7:0]    CARRIER_PIN_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic any_wr;
  assign any_wr = SFR_WR | SFR_BIT_WR;
  a_indirect_miss: assert property (SFR_INDIRECT |-> !SFR_HIT)
    else $error("indirect access hit");
  a_low_addr_miss: assert property (!SFR_ADDR[7] |-> !SFR_HIT)
    else $error("low address hit");
  a_miss_read: assert property (SFR_RD && !SFR_HIT |=> SFR_RVALID && SFR_RDATA == 8'h00)
    else $error("missed read not zero");
  a_acc_write: assert property (SFR_WR && SFR_HIT && SFR_ADDR == MCS_ADDR_ACC |=> ACC_OUT == $past(SFR_WDATA))
    else $error("accumulator write lost");
  a_parity_even: assert property (PSW_OUT[0] == ^ACC_OUT)
    else $error("parity odd");
  a_bank_base: assert property (BANK_SEL == PSW_OUT[4:3] && BANK_BASE == {BANK_SEL, 3'b000})
    else $error("bank select wrong");
  a_flag_update: assert property (CORE_UPD.alu_op inside {MCS_OP_ADD, MCS_OP_ADDC, MCS_OP_SUBB, MCS_OP_MUL,
    MCS_OP_DIV} && !any_wr |=> PSW_OUT[7] == $past(CORE_UPD.cy) && PSW_OUT[2] == $past(CORE_UPD.ov))
    else $error("carry or overflow not updated");
  a_aux_add_only: assert property (CORE_UPD.alu_op inside {MCS_OP_SUBB, MCS_OP_MUL, MCS_OP_DIV} && !any_wr
    |=> $stable(PSW_OUT[6])) else $error("aux carry changed");
  a_user_flags: assert property (!any_wr |=> $stable(PSW_OUT[5]) && $stable(PSW_OUT[1]))
    else $error("user flag changed");
  a_carrier_gate: assert property ((CARRIER_PIN_EN & ~CARRIER_PIN_SELECT) == 8'h00)
    else $error("carrier on unselected pin");
  c_bank_three: cover property (BANK_SEL == 2'b11);
  c_miss_read: cover property (SFR_RD && !SFR_HIT);
  c_add_op: cover property (CORE_UPD.alu_op == MCS_OP_ADD);
endmodule : mcs_core_sfr_checker

bind mcs_core_sfr mcs_core_sfr_checker i_mcs_core_sfr_checker (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
  .SFR_INDIRECT(SFR_INDIRECT), .SFR_RD(SFR_RD), .SFR_WR(SFR_WR), .SFR_BIT_WR(SFR_BIT_WR), .SFR_WDATA(SFR_WDATA),
  .SFR_HIT(SFR_HIT), .SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .CORE_UPD(CORE_UPD),
  .CARRIER_PIN_SELECT(CARRIER_PIN_SELECT), .ACC_OUT(ACC_OUT), .PSW_OUT(PSW_OUT), .BANK_SEL(BANK_SEL),
  .BANK_BASE(BANK_BASE), .CARRIER_PIN_EN(CARRIER_PIN_EN));

/* verification/tb.sv */
// Self-checking bench for the core register block.
// Drives all ports directly; no far-side model.
`timescale 1ns/100ps
module tb
  import mcs_pkg::*;
;
  logic          CLK, RST_N, SFR_INDIRECT, SFR_RD, SFR_WR, SFR_BIT_RD, SFR_BIT_WR, SFR_HIT, SFR_RVALID;
  logic          BAUD_DOUBLE, UART_ENHANCE, SERIAL_PORT_SPI, XRAM_MOVX_EN, CFG_KEEP_LOW;
  logic [7:0]    SFR_ADDR, SFR_WDATA, SFR_RDATA, CARRIER_PIN_SELECT, ACC_OUT, B_OUT, PSW_OUT, SP_OUT, CARRIER_PIN_EN;
  logic [15:0]   DPTR_OUT;
  logic [1:0]    BANK_SEL;
  logic [4:0]    BANK_BASE;
  mcs_core_upd_t CORE_UPD;
  int            fail_count, num_checks;
  logic [7:0]    ad [8] = '{MCS_ADDR_SP, MCS_ADDR_DPL, MCS_ADDR_DPH, MCS_ADDR_POWER_BAUD_CONTROL, MCS_ADDR_CFG, MCS_ADDR_PSW,
                           MCS_ADDR_ACC, MCS_ADDR_B};

  mcs_core_sfr i_mcs_core_sfr (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_INDIRECT(SFR_INDIRECT),
    .SFR_RD(SFR_RD), .SFR_WR(SFR_WR), .SFR_BIT_RD(SFR_BIT_RD), .SFR_BIT_WR(SFR_BIT_WR), .SFR_WDATA(SFR_WDATA),
    .SFR_HIT(SFR_HIT), .SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .CORE_UPD(CORE_UPD),
    .CARRIER_PIN_SELECT(CARRIER_PIN_SELECT), .ACC_OUT(ACC_OUT), .B_OUT(B_OUT), .PSW_OUT(PSW_OUT),
    .DPTR_OUT(DPTR_OUT), .SP_OUT(SP_OUT), .BANK_SEL(BANK_SEL), .BANK_BASE(BANK_BASE), .BAUD_DOUBLE(BAUD_DOUBLE),
    .UART_ENHANCE(UART_ENHANCE), .SERIAL_PORT_SPI(SERIAL_PORT_SPI), .CARRIER_PIN_EN(CARRIER_PIN_EN),
    .XRAM_MOVX_EN(XRAM_MOVX_EN), .CFG_KEEP_LOW(CFG_KEEP_LOW));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Kind bits: read, write, bit read, bit write
  task automatic acc(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d, output logic h,
                     output logic [7:0] r);
    @(posedge CLK);
    {SFR_RD, SFR_WR, SFR_BIT_RD, SFR_BIT_WR} <= k;
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    #1 h = SFR_HIT;
    @(posedge CLK);
    {SFR_RD, SFR_WR, SFR_BIT_RD, SFR_BIT_WR} <= 4'h0;
    #1 r = SFR_RDATA;
    if (k[3] | k[1]) chk(SFR_RVALID, 1'b1);
  endtask : acc

  task automatic upd(input mcs_core_upd_t u);
    @(posedge CLK);
    CORE_UPD <= u;
    @(posedge CLK);
    CORE_UPD <= '0;
    #1;
  endtask : upd

  task automatic t_reset;
    logic       h;
    logic [7:0] r;
    logic [7:0] ex [8] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      acc(4'h8, ad[i], 8'h00, h, r);
      chk(r, ex[i]);
    end
  endtask : t_reset

  task automatic t_rw;
    logic       h;
    logic [7:0] r, p;
    logic [7:0] ex [8];
    logic [7:0] w [8];
    for (int n = 0; n < 2; n++) begin
      p = n ? 8'h5a : 8'ha5;
      w = '{p, p, p, p & 8'h80, p | 8'h80, p, p, p};
      ex = '{p, p, p, p & 8'h80, (p | 8'h80) & 8'hf3, (p & 8'hfe) | {7'h0, ^p}, p, p};
      for (int i = 0; i < 8; i++) acc(4'h4, ad[i], w[i], h, r);
      for (int i = 0; i < 8; i++) begin
        acc(4'h8, ad[i], 8'h00, h, r);
        chk(r, ex[i]);
      end
      chk(DPTR_OUT, {p, p});
      chk({BAUD_DOUBLE, CFG_KEEP_LOW}, {p[7], 1'b0});
    end
  endtask : t_rw

  task automatic t_cfg;
    logic       h;
    logic [7:0] r;
    logic [7:0] v [4] = '{8'h80, 8'hd1, 8'hb2, 8'h83};
    for (int i = 0; i < 4; i++) begin
      acc(4'h4, MCS_ADDR_CFG, v[i], h, r);
      chk({UART_ENHANCE, SERIAL_PORT_SPI, XRAM_MOVX_EN}, {v[i][6], v[i][5], |v[i][1:0]});
      chk(CARRIER_PIN_EN, CARRIER_PIN_SELECT & {8{v[i][4]}});
    end
  endtask : t_cfg

  task automatic t_refused;
    logic       h;
    logic [7:0] r;
    logic [7:0] a [4] = '{8'he0, 8'h7f, 8'h90, 8'h80};
    acc(4'h4, MCS_ADDR_ACC, 8'h3c, h, r);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      SFR_INDIRECT <= (i == 0);
      acc(4'h4, a[i], 8'hff, h, r);
      chk(h, 1'b0);
      acc(i == 3 ? 4'h2 : 4'h8, a[i], 8'h00, h, r);
      chk({h, r}, 9'h000);
    end
    @(posedge CLK);
    SFR_INDIRECT <= 1'b0;
    chk(ACC_OUT, 8'h3c);
  endtask : t_refused

  task automatic t_bits;
    logic       h;
    logic [7:0] r;
    acc(4'h4, MCS_ADDR_PSW, 8'h00, h, r);
    acc(4'h4, MCS_ADDR_ACC, 8'h00, h, r);
    acc(4'h4, MCS_ADDR_B, 8'h00, h, r);
    for (int b = 0; b < 4; b++) begin
      acc(4'h1, 8'hd3, {7'h0, b[0]}, h, r);
      acc(4'h1, 8'hd4, {7'h0, b[1]}, h, r);
      chk({BANK_SEL, BANK_BASE}, {b[1:0], b[1:0], 3'b000});
    end
    acc(4'h1, 8'hd5, 8'h01, h, r);
    acc(4'h1, 8'hd1, 8'h01, h, r);
    acc(4'h2, 8'hd5, 8'h00, h, r);
    chk({h, r}, 9'h101);
    acc(4'h1, 8'he0, 8'h01, h, r);
    chk({ACC_OUT, PSW_OUT[0]}, 9'h003);
    acc(4'h1, 8'hf7, 8'h01, h, r);
    chk(B_OUT, 8'h80);
  endtask : t_bits

  task automatic t_alu;
    logic          h;
    logic [7:0]    r;
    mcs_core_upd_t u;
    for (int i = 1; i < 7; i++) begin
      acc(4'h4, MCS_ADDR_ACC, 8'h00, h, r);
      acc(4'h4, MCS_ADDR_PSW, 8'h22, h, r);
      u = '0;
      u.alu_op = mcs_alu_op_t'(i);
      {u.cy, u.ac, u.ov} = 3'b111;
      upd(u);
      chk(PSW_OUT, {i < 6, i < 3, 3'b100, i < 6, 2'b10});
    end
    acc(4'h4, MCS_ADDR_SP, 8'h10, h, r);
    acc(4'h4, MCS_ADDR_DPL, 8'hff, h, r);
    acc(4'h4, MCS_ADDR_DPH, 8'h00, h, r);
    u = '0;
    u.acc_we = 1'b1;
    u.acc = 8'h07;
    u.sp_op = MCS_SP_INC;
    u.dptr_inc = 1'b1;
    upd(u);
    chk(PSW_OUT[0], 1'b1);
    chk({SP_OUT, DPTR_OUT}, 24'h110100);
    u = '0;
    u.b_we = 1'b1;
    u.b = 8'h66;
    u.sp_op = MCS_SP_DEC;
    u.dptr_we = 1'b1;
    u.dptr = 16'h1234;
    upd(u);
    chk({B_OUT, SP_OUT, DPTR_OUT}, 32'h66101234);
  endtask : t_alu

  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    summarize();
  end

  initial begin
    RST_N = 1'b0;
    {SFR_INDIRECT, SFR_RD, SFR_WR, SFR_BIT_RD, SFR_BIT_WR} = '0;
    {SFR_ADDR, SFR_WDATA} = '0;
    CARRIER_PIN_SELECT = 8'h3c;
    CORE_UPD = '0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_rw();
    t_cfg();
    t_refused();
    t_bits();
    t_alu();
    summarize();
  end
endmodule : tb
